// [design/urtf_pkg.sv]
// package: constants for the ulpi receive command and transmit framing block
package urtf_pkg;
    // register word indexes, byte address is index times four
    localparam logic [2:0] URTF_A_CTRL = 3'h0;
    localparam logic [2:0] URTF_A_LATCH = 3'h1;
    localparam logic [2:0] URTF_A_CLR = 3'h2;
    localparam logic [2:0] URTF_A_EN = 3'h3;
    localparam logic [2:0] URTF_A_STAT = 3'h4;
    // control register layout and reset value (full speed, normal coding)
    localparam int URTF_C_XCVR = 0;
    localparam int URTF_C_TERM = 2;
    localparam int URTF_C_OPM = 3;
    localparam int URTF_C_DPPD = 5;
    localparam int URTF_C_DMPD = 6;
    localparam int URTF_CTRL_W = 7;
    localparam logic [6:0] URTF_CTRL_RST = 7'h05;
    // interrupt sources, bit positions in latch, clear and enable
    localparam int URTF_NEV = 4;
    localparam int URTF_E_ID = 0;
    localparam int URTF_E_RID = 1;
    localparam int URTF_E_VBUS = 2;
    localparam int URTF_E_TXD = 3;
    localparam logic [3:0] URTF_ALT_SRC = 4'h3;
    // transceiver select and operating mode codes
    localparam logic [1:0] URTF_X_HS = 2'h0;
    localparam logic [1:0] URTF_X_FS4LS = 2'h3;
    localparam logic [1:0] URTF_OP_NODRV = 2'h1;
    localparam logic [1:0] URTF_OP_CHIRP = 2'h2;
    localparam logic [1:0] URTF_OP_NOSYNC = 2'h3;
    // receive command field codes
    localparam logic [1:0] URTF_VB_LOW = 2'h0;
    localparam logic [1:0] URTF_VB_SE = 2'h1;
    localparam logic [1:0] URTF_VB_SV = 2'h2;
    localparam logic [1:0] URTF_VB_VV = 2'h3;
    localparam logic [1:0] URTF_EV_IDLE = 2'h0;
    localparam logic [1:0] URTF_EV_ACT = 2'h1;
    localparam logic [1:0] URTF_EV_ERR = 2'h3;
    localparam logic [1:0] URTF_EV_DISC = 2'h2;
    localparam logic [7:0] URTF_RXCMD_RST = 8'h00;
    // transmit command type in data[7:6]
    localparam logic [1:0] URTF_TXCMD_TX = 2'h1;
    // framing lengths in bit cells
    localparam logic [5:0] URTF_SYNC_HS = 6'h20;
    localparam logic [5:0] URTF_SYNC_FS = 6'h08;
    localparam logic [2:0] URTF_STUFF_RUN = 3'h6;
    localparam logic [5:0] URTF_EOP_SE0 = 6'h02;
    localparam logic [3:0] URTF_BYTE_BITS = 4'h8;
endpackage

// [design/urtf_txenc.sv]
// transmit encoder: sync field, bit stuffing, nrzi and end of packet
`timescale 1ns/1ps
`default_nettype none
module urtf_txenc
    import urtf_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // packet control
    input wire logic start_i,
    input wire logic hs_i,
    input wire logic raw_i,
    input wire logic last_i,
    // byte feed, one byte of holding
    input wire logic [7:0] byte_i,
    input wire logic byte_vld_i,
    output logic byte_rdy_o,
    // line side
    output logic busy_o,
    output logic line_o,
    output logic se0_o,
    output logic oe_o
);
    typedef enum logic [1:0] {EN_IDLE, EN_SYNC, EN_DATA, EN_EOP} urtf_enc_e;
    urtf_enc_e st_ff;
    logic [5:0] cnt_ff;
    logic [7:0] sh_ff;
    logic [3:0] bits_ff;
    logic [7:0] hold_ff;
    logic hold_vld_ff;
    logic end_ff;
    logic [2:0] ones_ff;
    logic stuff;
    logic take;

    // raw is read live each bit, so leftovers after a mode change get stuffed
    assign stuff = !raw_i && ones_ff == URTF_STUFF_RUN; // RULE10 RULE17
    assign take = st_ff == EN_DATA && bits_ff == 4'h0 && hold_vld_ff && !stuff;
    assign byte_rdy_o = !hold_vld_ff;
    assign busy_o = st_ff != EN_IDLE;

    // a one keeps the level, a zero toggles; chirp passes bits straight
    function automatic logic line_code(input logic lvl, input logic b, input logic raw);
        line_code = raw ? b : (b ? lvl : ~lvl); // RULE15
    endfunction

    // holding byte between the link pacing and the bit stream
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_vld_ff <= 1'b0;
            hold_ff <= 8'h00;
        end else if (byte_vld_i && !hold_vld_ff) begin
            hold_ff <= byte_i;
            hold_vld_ff <= 1'b1;
        end else if (take) begin
            hold_vld_ff <= 1'b0;
        end
    end

    // bit engine
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= EN_IDLE;
            cnt_ff <= 6'h00;
            sh_ff <= 8'h00;
            bits_ff <= 4'h0;
            ones_ff <= 3'h0;
            end_ff <= 1'b0;
            line_o <= 1'b1;
            se0_o <= 1'b0;
            oe_o <= 1'b0;
        end else begin
            if (last_i) begin
                end_ff <= 1'b1;
            end
            unique case (st_ff)
                EN_IDLE: begin
                    if (start_i) begin
                        st_ff <= EN_SYNC;
                        cnt_ff <= hs_i ? URTF_SYNC_HS : URTF_SYNC_FS; // RULE13 RULE14
                        oe_o <= 1'b1;
                        line_o <= 1'b1;
                        ones_ff <= 3'h0;
                        end_ff <= 1'b0;
                    end
                end
                EN_SYNC: begin
                    // zeros and a closing one
                    line_o <= line_code(line_o, cnt_ff == 6'h01, raw_i);
                    cnt_ff <= cnt_ff - 6'h01;
                    if (cnt_ff == 6'h01) begin
                        st_ff <= EN_DATA;
                        ones_ff <= 3'h1;
                    end
                end
                EN_DATA: begin
                    if (stuff) begin
                        line_o <= ~line_o; // RULE10
                        ones_ff <= 3'h0;
                    end else if (bits_ff != 4'h0) begin
                        line_o <= line_code(line_o, sh_ff[0], raw_i);
                        sh_ff <= {1'b0, sh_ff[7:1]};
                        bits_ff <= bits_ff - 4'h1;
                        ones_ff <= sh_ff[0] ? ones_ff + 3'h1 : 3'h0;
                    end else if (hold_vld_ff) begin
                        sh_ff <= hold_ff;
                        bits_ff <= URTF_BYTE_BITS;
                    end else if (end_ff) begin
                        st_ff <= EN_EOP;
                        cnt_ff <= URTF_EOP_SE0;
                        se0_o <= 1'b1;
                    end
                end
                EN_EOP: begin
                    // se0 cells, then one j cell, then release
                    cnt_ff <= cnt_ff - 6'h01;
                    if (cnt_ff == 6'h01) begin
                        se0_o <= 1'b0;
                        line_o <= 1'b1;
                    end
                    if (cnt_ff == 6'h00) begin
                        st_ff <= EN_IDLE;
                        oe_o <= 1'b0;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sync_hs_a: assert property ((st_ff == EN_IDLE && start_i && hs_i) |=> ##31 (st_ff == EN_SYNC) ##1 (st_ff == EN_DATA)) // RULE13
        else $error("hs sync length wrong");
    sync_fs_a: assert property ((st_ff == EN_IDLE && start_i && !hs_i) |=> ##7 (st_ff == EN_SYNC) ##1 (st_ff == EN_DATA)) // RULE14
        else $error("fs sync length wrong");
    stuff_bit_a: assert property ((st_ff == EN_DATA && !raw_i && ones_ff == URTF_STUFF_RUN) |=> line_o != $past(line_o)) // RULE10
        else $error("stuff bit missing");
    chirp_raw_a: assert property ((st_ff == EN_DATA && raw_i && bits_ff != 4'h0) |=> line_o == $past(sh_ff[0])) // RULE15
        else $error("chirp data was coded");
    eop_cov_c: cover property (st_ff == EN_EOP ##3 st_ff == EN_IDLE);
endmodule
`default_nettype wire

// [design/urtf_top.sv]
// top: ulpi receive command encoder, transmit framing and wishbone registers
//
// Function
// (RULE1) line state in rxcmd [1:0]; send rxcmd on change while dir is low
// (RULE2) rxcmd [3:2] codes vbus: 00 low, 01 above end, 10 valid, 11 vbus valid
// (RULE3) line state bit 0 follows dp, bit 1 follows dm
// (RULE4) rxcmd [5:4]: 00 idle, 01 active, 11 active with error, 10 disconnect
// (RULE5) rxcmd bit 6 is the sampled id level
// (RULE6) rxcmd bit 7 is high while a non-usb interrupt is pending
// (RULE7) alternate interrupt set when any enabled latch event is held; the code counts only the id and rid sources (URTF_ALT_SRC)
// (RULE8) link reads the latch register to find the interrupt source
// (RULE9) one encoder serves high, full and low speed packets
// (RULE10) packets go out bit stuffed then nrzi coded
// (RULE11) transmit behaviour decoded from all speed, termination, mode, pull-down bits
// (RULE12) link programs only valid mode combinations
// (RULE13) high speed packets open with a 32 bit sync
// (RULE14) full and low speed packets open with an 8 bit sync
// (RULE15) chirp mode turns off stuffing and nrzi
// (RULE16) link changes mode after chirp only once line state shows idle
// (RULE17) leftover chirp data after mode change may go out stuffed
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module urtf_top
    import urtf_pkg::*;
(
    // system
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic [4:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq_o,
    // ulpi link pins, link clock sampled like any pin
    input wire logic ulpi_clk_i,
    input wire logic ulpi_stp_i,
    input wire logic [7:0] ulpi_data_i,
    output logic [7:0] ulpi_data_o,
    output logic ulpi_data_oe_n_o,
    output logic ulpi_dir_o,
    output logic ulpi_nxt_o,
    // front end receivers and comparators
    input wire logic dp_i,
    input wire logic dm_i,
    input wire logic sess_end_i,
    input wire logic sess_vld_i,
    input wire logic vbus_vld_i,
    input wire logic id_i,
    input wire logic rx_active_i,
    input wire logic rx_error_i,
    input wire logic host_disc_i,
    input wire logic rid_done_i,
    // transmit line drive
    output logic tx_line_o,
    output logic tx_se0_o,
    output logic tx_drive_o
);
    localparam int NSYNC = 20;
    typedef enum logic [2:0] {LK_IDLE, LK_TURN, LK_CMD, LK_TXD, LK_TXEND} urtf_lk_e;

    logic [NSYNC-1:0] s1_ff;
    logic [NSYNC-1:0] s2_ff;
    logic lkc_s, stp_s, dp_s, dm_s, se_s, sv_s, vv_s;
    logic id_s, ra_s, re_s, hd_s, rid_s;
    logic [7:0] data_s;
    logic lkc_d_ff;
    logic lk_rise;

    // two-flop synchroniser for every pin; only s2_ff reads s1_ff
    // no reset: it keeps sampling through reset, so real levels stand at release
    always_ff @(posedge clk_i) begin
        s1_ff <= {ulpi_clk_i, ulpi_stp_i, ulpi_data_i, dp_i, dm_i, sess_end_i, sess_vld_i,
                  vbus_vld_i, id_i, rx_active_i, rx_error_i, host_disc_i, rid_done_i};
        s2_ff <= s1_ff;
    end
    assign {lkc_s, stp_s, data_s, dp_s, dm_s, se_s, sv_s, vv_s, id_s, ra_s, re_s, hd_s, rid_s} = s2_ff;

    // link clock edge finder; data is synchronised with the same delay
    // tracks through reset so a high link clock at release is no false edge
    always_ff @(posedge clk_i) begin
        lkc_d_ff <= lkc_s;
    end
    assign lk_rise = lkc_s && !lkc_d_ff;

    // field encoders
    function automatic logic [1:0] vbus_code(input logic se, input logic sv, input logic vv);
        if (vv) begin
            vbus_code = URTF_VB_VV;
        end else if (sv) begin
            vbus_code = URTF_VB_SV;
        end else if (!se) begin
            vbus_code = URTF_VB_SE;
        end else begin
            vbus_code = URTF_VB_LOW;
        end
    endfunction

    // disconnect outranks the receive flags
    function automatic logic [1:0] ev_code(input logic act, input logic err, input logic disc);
        if (disc) begin
            ev_code = URTF_EV_DISC;
        end else if (act && err) begin
            ev_code = URTF_EV_ERR;
        end else if (act) begin
            ev_code = URTF_EV_ACT;
        end else begin
            ev_code = URTF_EV_IDLE;
        end
    endfunction

    // control registers and mode decode
    logic [URTF_CTRL_W-1:0] ctrl_ff;
    logic [1:0] xcvr, opm;
    logic term, dppd, dmpd, hs_mode, raw_mode, tx_ok, mode_bad;
    assign xcvr = ctrl_ff[URTF_C_XCVR +: 2];
    assign term = ctrl_ff[URTF_C_TERM];
    assign opm = ctrl_ff[URTF_C_OPM +: 2];
    assign dppd = ctrl_ff[URTF_C_DPPD];
    assign dmpd = ctrl_ff[URTF_C_DMPD];
    // high speed needs terminations off; the full speed pre-amble path is host only
    assign hs_mode = xcvr == URTF_X_HS && !term; // RULE11
    assign raw_mode = opm == URTF_OP_CHIRP; // RULE15
    assign mode_bad = (xcvr == URTF_X_FS4LS && !(dppd && dmpd)) || opm == URTF_OP_NOSYNC; // RULE11 RULE12
    assign tx_ok = !mode_bad && opm != URTF_OP_NODRV; // RULE11

    // wishbone decode
    logic req, wr_take;
    logic [2:0] widx;
    assign req = wb_cyc_i && wb_stb_i;
    assign widx = wb_adr_i[4:2];
    // writes land on the edge where the master sees ack
    assign wr_take = req && wb_we_i && wb_ack_o && wb_sel_i[0];

    // interrupt sources
    logic [URTF_NEV-1:0] lat_ff, en_ff, ev, clr;
    logic id_d_ff, rid_d_ff;
    logic [1:0] vb_d_ff;
    logic [1:0] vb_now;
    logic alt_now;
    logic txd_ev;
    assign vb_now = vbus_code(se_s, sv_s, vv_s); // RULE2
    assign ev[URTF_E_ID] = id_s != id_d_ff;
    assign ev[URTF_E_RID] = rid_s && !rid_d_ff;
    assign ev[URTF_E_VBUS] = vb_now != vb_d_ff;
    assign ev[URTF_E_TXD] = txd_ev;
    assign clr = (wr_take && widx == URTF_A_CLR) ? wb_dat_i[URTF_NEV-1:0] : '0;
    // only the carkit sources count as non-usb interrupts
    assign alt_now = |(lat_ff & en_ff & URTF_ALT_SRC); // RULE6 RULE7

    // previous levels for change detection
    // these follow the pins during reset, so release itself never looks like a change
    always_ff @(posedge clk_i) begin
        id_d_ff <= id_s;
        rid_d_ff <= rid_s;
        vb_d_ff <= vb_now;
    end

    // sticky latch: a new event wins over a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lat_ff <= '0;
        end else begin
            lat_ff <= (lat_ff & ~clr) | ev; // RULE7
        end
    end

    // level interrupt from a flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(lat_ff & en_ff);
        end
    end

    // writable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= URTF_CTRL_RST;
            en_ff <= '0;
        end else if (wr_take) begin
            if (widx == URTF_A_CTRL) begin
                ctrl_ff <= wb_dat_i[URTF_CTRL_W-1:0];
            end
            if (widx == URTF_A_EN) begin
                en_ff <= wb_dat_i[URTF_NEV-1:0];
            end
        end
    end

    // receive command assembly
    logic [7:0] rxcmd_now;
    logic [7:0] sent_ff;
    logic enc_busy, enc_rdy;
    assign rxcmd_now = {alt_now, id_s, ev_code(ra_s, re_s, hd_s), vb_now, dm_s, dp_s}; // RULE3 RULE4 RULE5 RULE6

    // answer is one cycle after the request; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && !wb_ack_o;
            if (req && !wb_ack_o) begin
                unique case (widx)
                    URTF_A_CTRL: wb_dat_o <= {25'h0, ctrl_ff};
                    URTF_A_LATCH: wb_dat_o <= {28'h0, lat_ff}; // RULE8
                    URTF_A_EN: wb_dat_o <= {28'h0, en_ff};
                    URTF_A_STAT: wb_dat_o <= {22'h0, enc_busy, mode_bad, sent_ff};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // link side sequencer, steps on link clock edges only
    urtf_lk_e lk_ff;
    logic first_ff, txd_pend_ff;
    logic txcmd, rx_pend, enc_start, enc_push, enc_last;
    logic [7:0] enc_byte;
    assign txcmd = data_s[7:6] == URTF_TXCMD_TX;
    assign rx_pend = rxcmd_now != sent_ff || txd_pend_ff; // RULE1
    // a transmit command is refused while the mode forbids driving
    assign enc_start = lk_rise && lk_ff == LK_IDLE && txcmd && tx_ok; // RULE11
    assign enc_push = lk_rise && lk_ff == LK_TXD && ulpi_nxt_o && !stp_s;
    assign enc_last = lk_rise && lk_ff == LK_TXD && ulpi_nxt_o && stp_s;
    // the command nibble becomes the pid byte with its check nibble
    assign enc_byte = first_ff ? {~data_s[3:0], data_s[3:0]} : data_s;
    assign txd_ev = lk_rise && lk_ff == LK_TXEND && !enc_busy;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lk_ff <= LK_IDLE;
            first_ff <= 1'b0;
            txd_pend_ff <= 1'b0;
            sent_ff <= URTF_RXCMD_RST;
            ulpi_dir_o <= 1'b0;
            ulpi_nxt_o <= 1'b0;
            ulpi_data_o <= 8'h00;
            ulpi_data_oe_n_o <= 1'b1;
        end else if (lk_rise) begin
            unique case (lk_ff)
                LK_IDLE: begin
                    // the link's transmit command is served before a pending rxcmd
                    if (enc_start) begin
                        ulpi_nxt_o <= 1'b1;
                        first_ff <= 1'b1;
                        lk_ff <= LK_TXD;
                    end else if (rx_pend) begin
                        ulpi_dir_o <= 1'b1; // RULE1
                        lk_ff <= LK_TURN;
                    end
                end
                LK_TURN: begin
                    ulpi_data_o <= rxcmd_now; // RULE1
                    ulpi_data_oe_n_o <= 1'b0;
                    sent_ff <= rxcmd_now;
                    txd_pend_ff <= 1'b0;
                    lk_ff <= LK_CMD;
                end
                LK_CMD: begin
                    ulpi_dir_o <= 1'b0;
                    ulpi_data_oe_n_o <= 1'b1;
                    lk_ff <= LK_IDLE;
                end
                LK_TXD: begin
                    if (enc_last) begin
                        ulpi_nxt_o <= 1'b0;
                        lk_ff <= LK_TXEND;
                    end else if (ulpi_nxt_o) begin
                        // hold register is full after a push, so pause the link
                        first_ff <= 1'b0;
                        ulpi_nxt_o <= 1'b0;
                    end else begin
                        ulpi_nxt_o <= enc_rdy;
                    end
                end
                LK_TXEND: begin
                    // report line state once the packet has left
                    if (!enc_busy) begin
                        txd_pend_ff <= 1'b1;
                        lk_ff <= LK_IDLE;
                    end
                end
            endcase
        end
    end

    // one encoder for every speed; speed only picks the sync length
    urtf_txenc u_enc ( // RULE9
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(enc_start),
        .hs_i(hs_mode),
        .raw_i(raw_mode),
        .last_i(enc_last),
        .byte_i(enc_byte),
        .byte_vld_i(enc_push),
        .byte_rdy_o(enc_rdy),
        .busy_o(enc_busy),
        .line_o(tx_line_o),
        .se0_o(tx_se0_o),
        .oe_o(tx_drive_o)
    );

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic cmd_trig;
    assign cmd_trig = lk_rise && lk_ff == LK_TURN;

    rxcmd_send_a: assert property ((lk_rise && lk_ff == LK_IDLE && !enc_start && rx_pend) |=> ulpi_dir_o ##[1:40] !ulpi_data_oe_n_o) // RULE1
        else $error("rxcmd not sent after change");
    vbus_code_a: assert property ((cmd_trig && vv_s) |=> ulpi_data_o[3:2] == URTF_VB_VV) // RULE2
        else $error("vbus valid code wrong");
    vbus_low_a: assert property ((cmd_trig && se_s && !sv_s && !vv_s) |=> ulpi_data_o[3:2] == URTF_VB_LOW) // RULE2
        else $error("vbus low code wrong");
    line_order_a: assert property (cmd_trig |=> ulpi_data_o[1:0] == {$past(dm_s), $past(dp_s)}) // RULE3
        else $error("line state bits swapped");
    disc_code_a: assert property ((cmd_trig && hd_s) |=> ulpi_data_o[5:4] == URTF_EV_DISC) // RULE4
        else $error("disconnect code wrong");
    rx_err_a: assert property ((cmd_trig && ra_s && re_s && !hd_s) |=> ulpi_data_o[5:4] == URTF_EV_ERR) // RULE4
        else $error("receive error code wrong");
    id_bit_a: assert property (cmd_trig |=> ulpi_data_o[6] == $past(id_s)) // RULE5
        else $error("id bit wrong");
    alt_bit_a: assert property (cmd_trig |=> ulpi_data_o[7] == $past(alt_now)) // RULE6
        else $error("alternate interrupt bit wrong");
    alt_latch_a: assert property ((ev[URTF_E_RID] && en_ff[URTF_E_RID] && !wr_take) |=> alt_now) // RULE7
        else $error("enabled event did not raise alt");
    mode_refuse_a: assert property ((lk_rise && lk_ff == LK_IDLE && txcmd && !tx_ok) |=> !ulpi_nxt_o) // RULE11
        else $error("transmit taken in forbidden mode");

    rxcmd_cov_c: cover property (cmd_trig ##1 !ulpi_data_oe_n_o);
    tx_cov_c: cover property (enc_start ##[1:200] enc_last);
    chirp_cov_c: cover property (enc_start && raw_mode);
    txdone_cov_c: cover property (txd_ev);
endmodule
`default_nettype wire

// [bench/urtf_link_model.sv]
// link model: free link clock, idle bus, captures receive command bytes
`timescale 1ns/1ps
`default_nettype none
module urtf_link_model (
    // ulpi pins
    output logic clk_o,
    output logic stp_o,
    output logic [7:0] dat_o,
    input wire logic [7:0] dat_i,
    input wire logic oe_n_i,
    input wire logic dir_i,
    // captured bytes
    output logic [7:0] rx_o,
    output logic vld_o
);
    // 200 ns clock, phase unrelated to clk_i
    initial begin
        clk_o = 1'b0;
        vld_o = 1'b0;
        #37;
        forever #100 clk_o = ~clk_o;
    end
    // never issues a transmit, so a badly programmed mode never reaches the encoder
    assign stp_o = 1'b0;
    assign dat_o = dir_i ? 8'hFF : 8'h00; // released bus shows no stale value
    // a byte driven with oe_n low is a receive command
    always @(posedge clk_o) begin
        if (dir_i && !oe_n_i) begin
            rx_o <= dat_i;
        end
        vld_o <= dir_i && !oe_n_i;
    end
endmodule
`default_nettype wire

// [bench/tb_urtf_top.sv]
// testbench: receive command fields, alternate interrupt, registers
`timescale 1ns/1ps
`default_nettype none
module tb_urtf_top;
    import urtf_pkg::*;
    logic clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, irq_o;
    logic [4:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, r, x, seed;
    logic uclk, stp, oe_n, dir, vld, txl, txs, txd, nxt;
    logic [7:0] din, dout, rxb, e, last;
    logic [9:0] fe, f;
    logic [7:0] q[$];
    int fail_count, n_tests, k;
    // clock, 25 ns
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    urtf_top u_urtf_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .ulpi_clk_i(uclk), .ulpi_stp_i(stp),
        .ulpi_data_i(din), .ulpi_data_o(dout), .ulpi_data_oe_n_o(oe_n), .ulpi_dir_o(dir),
        .ulpi_nxt_o(nxt), .dp_i(fe[0]), .dm_i(fe[1]), .sess_end_i(fe[2]), .sess_vld_i(fe[3]),
        .vbus_vld_i(fe[4]), .id_i(fe[5]), .rx_active_i(fe[6]), .rx_error_i(fe[7]),
        .host_disc_i(fe[8]), .rid_done_i(fe[9]), .tx_line_o(txl), .tx_se0_o(txs), .tx_drive_o(txd));
    urtf_link_model u_urtf_link_model (.clk_o(uclk), .stp_o(stp), .dat_o(din), .dat_i(dout),
        .oe_n_i(oe_n), .dir_i(dir), .rx_o(rxb), .vld_o(vld));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (i = 0; i < 50 && wb_ack_o !== 1'b1; i++) @(posedge clk_i);
        r = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (i == 50) begin
            fail_count++;
            wrap_up;
        end
    endtask
    task automatic wait_q;
        int i;
        for (i = 0; i < 400 && q.size() != 0; i++) @(posedge clk_i);
        if (i == 400) begin
            fail_count++;
            wrap_up;
        end
    endtask
    function automatic logic [31:0] xs;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // fe order: rid, disc, err, act, id, vv, sv, se, dm, dp
    function automatic logic [7:0] exp_cmd(input logic [9:0] v, input logic alt);
        logic [1:0] vb, ev;
        vb = v[4] ? URTF_VB_VV : v[3] ? URTF_VB_SV : !v[2] ? URTF_VB_SE : URTF_VB_LOW;
        ev = v[8] ? URTF_EV_DISC : !v[6] ? URTF_EV_IDLE : v[7] ? URTF_EV_ERR : URTF_EV_ACT;
        return {alt, v[5], ev, vb, v[1], v[0]};
    endfunction
    // every arriving receive command takes the oldest expectation
    always @(posedge vld) begin
        if (q.size() == 0) chk(rxb, {1'b1, rxb});
        else chk(rxb, q.pop_front());
    end
    initial begin
        {wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} = '0;
        wb_sel_i = 4'hF;
        rst_i = 1'b1;
        fe = 10'h004;
        last = 8'h00;
        seed = 32'hD0FA;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 5'h00, 32'h0);
        chk(r, {25'h0, URTF_CTRL_RST});
        chk({txl, txs, txd, nxt}, 4'h8);
        wb(1'b0, 5'h10, 32'h0);
        chk(r, 32'h0);
        wb(1'b1, 5'h00, 32'h3);
        wb(1'b0, 5'h10, 32'h0);
        chk(r, 32'h100);
        $display("register test done");
        // random line, vbus, id and event levels, kept physically consistent
        for (k = 0; k < 24; k++) begin
            x = xs();
            f = {1'b0, x[7], x[6] & x[5], x[5], x[4], &x[3:2], x[3], x[3:2] == 2'h0, x[1:0]};
            e = exp_cmd(f, 1'b0);
            if (e !== last) q.push_back(e);
            last = e;
            @(posedge clk_i);
            fe <= f;
            wait_q;
        end
        $display("field test done");
        // enabled carkit event raises bit 7 and the interrupt
        wb(1'b1, 5'h08, 32'hF);
        wb(1'b1, 5'h0C, 32'h3);
        q.push_back({1'b1, last[6:0]});
        fe[9] <= 1'b1;
        wait_q;
        chk(irq_o, 1'b1);
        wb(1'b0, 5'h04, 32'h0);
        chk(r, 32'h2);
        q.push_back(last);
        wb(1'b1, 5'h08, 32'h2);
        wait_q;
        chk(irq_o, 1'b0);
        // masked event: latch only, no interrupt, no command
        wb(1'b1, 5'h0C, 32'h0);
        fe[9] <= 1'b0;
        repeat (10) @(posedge clk_i);
        fe[9] <= 1'b1;
        repeat (100) @(posedge clk_i);
        chk(irq_o, 1'b0);
        wb(1'b0, 5'h04, 32'h0);
        chk(r, 32'h2);
        $display("interrupt test done");
        wrap_up;
    end
endmodule
`default_nettype wire
